// file: include/msu_pkg.sv
// constants, field layouts and state codes shared by the serial channel logic
package msu_pkg;
    // ************************************************************
    // channel modes and word formats
    // ************************************************************
    localparam logic [1:0] MODE_CLOCKED = 2'h0;  // three-wire clocked link
    localparam logic [1:0] MODE_SELECTED = 2'h1; // four-wire slave with select
    localparam logic [1:0] MODE_ASYNC = 2'h2;    // start/stop framed link
    localparam logic [1:0] MODE_TWO_WIRE = 2'h3; // single-master two-wire bus
    localparam logic [1:0] LEN_7 = 2'h0;
    localparam logic [1:0] LEN_8 = 2'h1;
    localparam logic [1:0] LEN_9 = 2'h2;
    localparam logic [3:0] BITS_7 = 4'h7;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam int WORD_W = 9;
    // ************************************************************
    // sticky error flag positions and widths
    // ************************************************************
    localparam int FLAG_W = 4;
    localparam int FLAG_OVERRUN = 0;
    localparam int FLAG_PARITY = 1;
    localparam int FLAG_FRAMING = 2;
    localparam int FLAG_NO_ACK = 3;
    localparam int PRESC_W = 15;
    localparam int SEL_W = 4;
    localparam int DIV_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam logic IDLE_MARK = 1'b1;
    // ************************************************************
    // bit engine states, gray along start-data-parity-stop
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_DATA = 3'h3,
        ST_PARITY = 3'h2,
        ST_STOP = 3'h6,
        ST_ACK = 3'h7
    } link_state_t;
endpackage : msu_pkg

// file: src/multi_mode_serial_unit.sv
// multi-mode serial unit: clocked, selected-slave, async and two-wire channels
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// two-entry style buffer with overwrite of the newest word when full
// ************************************************************
module word_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic overwrite_in,
    // draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic full;
    logic push;
    logic pop;

    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign in_ready_out = ~full;
    assign out_valid_out = wp != rp;
    assign out_data_out = mem[rp[AW-1:0]];
    assign push = in_valid_in & ~full;
    assign pop = out_valid_out & out_ready_in;

    // pointers; a full push with overwrite replaces the newest entry in place
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop) rp <= rp + 1'b1;
        end
    end

    // storage
    always_ff @(posedge mclk_in) begin
        if (push) mem[wp[AW-1:0]] <= in_data_in;
        else if (in_valid_in && overwrite_in) mem[AW'(wp[AW-1:0] - 1'b1)] <= in_data_in;
    end
endmodule : word_buffer

// What this block does
// - four units of up to four channels; each channel picks its mode.
// - three-wire mode: one clock, one send and one receive line, master clocks.
// - clocked words are seven or eight bits, either bit first.
// - master clock at most half system clock; slave clock at most mck/6.
// - clocked channels choose master or slave and clock/data phase.
// - bit period comes from a shared prescaler and a per-channel counter.
// - clocked mode gives done and buffer-empty events and overrun flag.
// - four-wire variant is slave only, gated by select, with level inversion.
// - async frames hold start, data, optional parity, stop at internal baud.
// - async full duplex pairs even channel sending with odd channel receiving.
// - async words are seven, eight or nine bits, bit order, line inversion.
// - async sender adds parity and stop; receiver checks both.
// - async receiver flags framing, parity, overrun and raises error event.
// - received line level is offered to a capture timer and external interrupt.
// - two-wire mode is single bus master sending and receiving only.
// - two-wire bytes are eight bits; address byte carries read/write in bit zero.
// - two-wire mode sends and checks acknowledge, flags missing one and overrun.
// - two-wire mode gives an end event after every byte.
// - no slave, arbitration loss or clock-stretch detection in two-wire mode.
module multi_mode_serial_unit #(
    parameter int CHANNELS = 4
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // per-channel configuration
    input wire logic [CHANNELS-1:0] enable_in,
    input wire logic [2*CHANNELS-1:0] mode_in,
    input wire logic [CHANNELS-1:0] master_in,
    input wire logic [2*CHANNELS-1:0] word_len_in,
    input wire logic [CHANNELS-1:0] msb_first_in,
    input wire logic [CHANNELS-1:0] clk_pol_in,
    input wire logic [CHANNELS-1:0] clk_phase_in,
    input wire logic [CHANNELS-1:0] invert_in,
    input wire logic [2*CHANNELS-1:0] parity_in,
    input wire logic [CHANNELS-1:0] two_wire_read_in,
    input wire logic [CHANNELS-1:0] ack_enable_in,
    input wire logic [msu_pkg::SEL_W*CHANNELS-1:0] presc_sel_in,
    input wire logic [msu_pkg::DIV_W*CHANNELS-1:0] divider_in,
    input wire logic [CHANNELS-1:0] sw_clk_level_in,
    input wire logic [CHANNELS-1:0] sw_data_level_in,
    input wire logic [msu_pkg::FLAG_W*CHANNELS-1:0] flag_clear_in,
    // words to send
    input wire logic [msu_pkg::WORD_W*CHANNELS-1:0] tx_data_in,
    input wire logic [CHANNELS-1:0] tx_valid_in,
    output logic [CHANNELS-1:0] tx_ready_out,
    // words received
    output logic [msu_pkg::WORD_W*CHANNELS-1:0] rx_data_out,
    output logic [CHANNELS-1:0] rx_valid_out,
    input wire logic [CHANNELS-1:0] rx_ready_in,
    // serial pins
    input wire logic [CHANNELS-1:0] sck_in,
    output logic [CHANNELS-1:0] sck_out,
    output logic [CHANNELS-1:0] sck_oe_out,
    input wire logic [CHANNELS-1:0] si_in,
    output logic [CHANNELS-1:0] so_out,
    output logic [CHANNELS-1:0] so_oe_out,
    input wire logic [CHANNELS-1:0] slave_select_input_b_in,
    // status and events
    output logic [msu_pkg::FLAG_W*CHANNELS-1:0] flags_out,
    output logic [CHANNELS-1:0] busy_out,
    output logic [CHANNELS-1:0] done_out,
    output logic [CHANNELS-1:0] buf_empty_out,
    output logic [CHANNELS-1:0] error_out,
    output logic [CHANNELS-1:0] rx_line_level_out
);
    // ************************************************************
    // shared prescaler
    // ************************************************************
    logic [msu_pkg::PRESC_W-1:0] presc;
    logic [msu_pkg::PRESC_W:0] pre_en;

    // free-running count; each tap yields a one-cycle enable at clk/2^k
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) presc <= '0;
        else presc <= presc + 1'b1;
    end

    assign pre_en[0] = 1'b1;
    genvar k;
    for (k = 1; k <= msu_pkg::PRESC_W; k++) begin : g_tap
        assign pre_en[k] = &presc[k-1:0];
    end

    // bit position of the n-th bit on the line
    function automatic logic [3:0] pos(input logic [3:0] n, input logic [3:0] nb,
                                       input logic msb);
        pos = msb ? (nb - 4'h1 - n) : n;
    endfunction

    // ************************************************************
    // channels (four units = four instances of this module)
    // ************************************************************
    genvar c;
    for (c = 0; c < CHANNELS; c++) begin : g_ch
        localparam bit RX_SIDE = (c % 2) == 1;
        localparam int W = msu_pkg::WORD_W;
        msu_pkg::link_state_t state;
        logic [1:0] md;
        logic uart, iic, css, slave, ss_act, inv_act, par_en, odd, rx_uart;
        logic pol_e, cpha_e, din, tick, mid, endb, last, take, run;
        logic [3:0] nb;
        logic [W-1:0] mask, wsel, tx_d, rx_d;
        logic tx_v, rx_rdy, tpar, rpar, push;
        logic half, txbit, sck_r, rxl_q, sck_q, fin, perr, ferr, nack, txv_q;
        logic [3:0] bitn;
        logic [W-1:0] txw, rxw;
        logic [msu_pkg::DIV_W-1:0] cnt, div;
        logic [msu_pkg::SEL_W-1:0] sel;
        logic [msu_pkg::FLAG_W-1:0] flags, fset, fclr;

        // mode decode
        assign md = mode_in[2*c +: 2];
        assign uart = md == msu_pkg::MODE_ASYNC;
        assign iic = md == msu_pkg::MODE_TWO_WIRE;
        assign css = md == msu_pkg::MODE_SELECTED;
        assign slave = css | ((md == msu_pkg::MODE_CLOCKED) & ~master_in[c]);
        assign ss_act = ~css | ~slave_select_input_b_in[c];
        assign inv_act = invert_in[c] & (uart | css);
        assign rx_uart = uart & RX_SIDE;
        assign par_en = uart & (parity_in[2*c +: 2] != msu_pkg::PAR_NONE);
        assign odd = parity_in[2*c +: 2] == msu_pkg::PAR_ODD;
        assign pol_e = iic ? 1'b0 : clk_pol_in[c];
        assign cpha_e = iic ? 1'b0 : clk_phase_in[c];
        assign sel = presc_sel_in[msu_pkg::SEL_W*c +: msu_pkg::SEL_W];
        assign div = divider_in[msu_pkg::DIV_W*c +: msu_pkg::DIV_W];
        assign din = si_in[c] ^ inv_act;

        // word length: two-wire fixed at eight, nine only for async
        always_comb begin
            nb = msu_pkg::BITS_8;
            if (!iic && word_len_in[2*c +: 2] == msu_pkg::LEN_7) nb = msu_pkg::BITS_7;
            if (uart && word_len_in[2*c +: 2] == msu_pkg::LEN_9) nb = msu_pkg::BITS_9;
        end
        assign mask = (nb == msu_pkg::BITS_9) ? 9'h1FF : (nb == msu_pkg::BITS_8) ? 9'h0FF : 9'h07F;
        assign last = bitn == (nb - 4'h1);
        assign tpar = (^(txw & mask)) ^ odd;
        assign rpar = (^(rxw & mask)) ^ odd;

        // per-channel counter on the selected tap; div 0 at tap 0 gives clk/2 bits
        assign run = enable_in[c] & ~slave & (state != msu_pkg::ST_IDLE);
        assign tick = run & pre_en[sel] & (cnt == '0);
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) cnt <= '0;
            else if (!run) cnt <= div;
            else if (pre_en[sel]) cnt <= (cnt == '0) ? div : cnt - 1'b1;
        end

        // edge history of the incoming clock and line; inputs are synchronous
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                sck_q <= 1'b0;
                rxl_q <= msu_pkg::IDLE_MARK;
                txv_q <= 1'b0;
            end else begin
                sck_q <= sck_in[c];
                rxl_q <= din;
                txv_q <= tx_v;
            end
        end

        // slave: sampling edge takes the first half, shifting edge the second
        always_comb begin
            mid = tick & ~half;
            endb = tick & half;
            if (slave) begin
                mid = ~half & (sck_in[c] != sck_q) & ((sck_in[c] == pol_e) == cpha_e);
                endb = half & (sck_in[c] != sck_q) & ((sck_in[c] == pol_e) != cpha_e);
            end
        end

        assign take = (state == msu_pkg::ST_IDLE) & enable_in[c] & ~rx_uart
            & (slave ? ss_act : tx_v);
        assign wsel = tx_v ? tx_d : '1;

        // bit engine, one frame per pass from idle back to idle
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                state <= msu_pkg::ST_IDLE;
                half <= 1'b0;
                bitn <= 4'h0;
                txw <= '0;
                rxw <= '0;
                txbit <= msu_pkg::IDLE_MARK;
                sck_r <= 1'b0;
                fin <= 1'b0;
                perr <= 1'b0;
                ferr <= 1'b0;
                nack <= 1'b0;
            end else begin
                fin <= 1'b0;
                perr <= 1'b0;
                ferr <= 1'b0;
                nack <= 1'b0;
                if (!enable_in[c] || !ss_act) begin
                    // a dropped select aborts the word mid-way
                    state <= msu_pkg::ST_IDLE;
                    half <= 1'b0;
                end else begin
                    case (state)
                        msu_pkg::ST_IDLE: begin
                            half <= 1'b0;
                            bitn <= 4'h0;
                            rxw <= '0;
                            sck_r <= iic ? sw_clk_level_in[c] : pol_e;
                            txbit <= iic ? sw_data_level_in[c] : msu_pkg::IDLE_MARK;
                            if (rx_uart && rxl_q && !din) begin
                                state <= msu_pkg::ST_START;
                            end else if (take) begin
                                txw <= wsel;
                                state <= uart ? msu_pkg::ST_START : msu_pkg::ST_DATA;
                                txbit <= uart ? 1'b0 : wsel[pos(4'h0, nb, msb_first_in[c])];
                                sck_r <= pol_e ^ cpha_e;
                            end
                        end
                        msu_pkg::ST_START: begin
                            if (mid) begin
                                half <= 1'b1;
                                if (rx_uart && din) state <= msu_pkg::ST_IDLE; // glitch, not a start
                            end else if (endb) begin
                                half <= 1'b0;
                                state <= msu_pkg::ST_DATA;
                                txbit <= txw[pos(4'h0, nb, msb_first_in[c])];
                            end
                        end
                        msu_pkg::ST_DATA: begin
                            if (mid) begin
                                half <= 1'b1;
                                rxw[pos(bitn, nb, msb_first_in[c])] <= din;
                                if (!uart) sck_r <= pol_e ^ ~cpha_e;
                                if (slave && last) begin
                                    fin <= 1'b1;
                                    state <= msu_pkg::ST_IDLE;
                                end
                            end else if (endb) begin
                                half <= 1'b0;
                                if (!uart) sck_r <= pol_e ^ cpha_e;
                                if (!last) begin
                                    bitn <= bitn + 4'h1;
                                    txbit <= txw[pos(bitn + 4'h1, nb, msb_first_in[c])];
                                end else if (iic) begin
                                    state <= msu_pkg::ST_ACK;
                                    txbit <= two_wire_read_in[c] ? ~ack_enable_in[c] : 1'b1;
                                end else if (uart) begin
                                    state <= par_en ? msu_pkg::ST_PARITY : msu_pkg::ST_STOP;
                                    txbit <= par_en ? tpar : msu_pkg::IDLE_MARK;
                                end else begin
                                    state <= msu_pkg::ST_IDLE;
                                    fin <= 1'b1;
                                    sck_r <= pol_e;
                                end
                            end
                        end
                        msu_pkg::ST_PARITY: begin
                            if (mid) begin
                                half <= 1'b1;
                                if (rx_uart) perr <= din ^ rpar;
                            end else if (endb) begin
                                half <= 1'b0;
                                state <= msu_pkg::ST_STOP;
                                txbit <= msu_pkg::IDLE_MARK;
                            end
                        end
                        msu_pkg::ST_STOP: begin
                            // receiver ends at mid-stop so the next start edge is not missed
                            if (mid) begin
                                half <= 1'b1;
                                if (rx_uart) begin
                                    ferr <= ~din;
                                    fin <= 1'b1;
                                    state <= msu_pkg::ST_IDLE;
                                end
                            end else if (endb) begin
                                half <= 1'b0;
                                fin <= 1'b1;
                                state <= msu_pkg::ST_IDLE;
                            end
                        end
                        msu_pkg::ST_ACK: begin
                            if (mid) begin
                                half <= 1'b1;
                                sck_r <= 1'b1;
                                nack <= ~two_wire_read_in[c] & din;
                            end else if (endb) begin
                                half <= 1'b0;
                                sck_r <= 1'b0;
                                txbit <= 1'b1;
                                fin <= 1'b1;
                                state <= msu_pkg::ST_IDLE;
                            end
                        end
                        default: state <= msu_pkg::ST_IDLE;
                    endcase
                end
            end
        end

        // buffers on both data paths; a full receive side is overwritten
        word_buffer #(.WIDTH(W), .DEPTH(msu_pkg::BUF_DEPTH)) u_tx (
            .mclk_in(mclk_in),
            .rst_b_in(rst_b_in),
            .in_valid_in(tx_valid_in[c]),
            .in_ready_out(tx_ready_out[c]),
            .in_data_in(tx_data_in[W*c +: W]),
            .overwrite_in(1'b0),
            .out_valid_out(tx_v),
            .out_ready_in(take),
            .out_data_out(tx_d)
        );
        assign push = fin & (rx_uart | (~uart & ~iic) | (iic & two_wire_read_in[c]));
        assign rx_d = rxw & mask;
        word_buffer #(.WIDTH(W), .DEPTH(msu_pkg::BUF_DEPTH)) u_rx (
            .mclk_in(mclk_in),
            .rst_b_in(rst_b_in),
            .in_valid_in(push),
            .in_ready_out(rx_rdy),
            .in_data_in(rx_d),
            .overwrite_in(1'b1),
            .out_valid_out(rx_valid_out[c]),
            .out_ready_in(rx_ready_in[c]),
            .out_data_out(rx_data_out[W*c +: W])
        );

        // sticky flags: a set in the clearing cycle wins
        always_comb begin
            fset = '0;
            fset[msu_pkg::FLAG_OVERRUN] = push & ~rx_rdy;
            fset[msu_pkg::FLAG_PARITY] = perr;
            fset[msu_pkg::FLAG_FRAMING] = ferr;
            fset[msu_pkg::FLAG_NO_ACK] = nack;
        end
        assign fclr = flag_clear_in[msu_pkg::FLAG_W*c +: msu_pkg::FLAG_W];
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                flags <= '0;
                done_out[c] <= 1'b0;
                buf_empty_out[c] <= 1'b0;
                error_out[c] <= 1'b0;
            end else begin
                flags <= (flags & ~fclr) | fset;
                done_out[c] <= fin;
                buf_empty_out[c] <= txv_q & ~tx_v & ~uart_rx_only(rx_uart);
                error_out[c] <= |fset;
            end
        end

        // pin drive; two-wire lines are open drain, driven only when low
        assign sck_out[c] = iic ? 1'b0 : sck_r;
        assign sck_oe_out[c] = enable_in[c] & ~slave & ~uart & (~iic | ~sck_r);
        assign so_out[c] = iic ? 1'b0 : (txbit ^ inv_act);
        assign so_oe_out[c] = enable_in[c] & ~rx_uart & (iic ? ~txbit : ss_act);
        assign flags_out[msu_pkg::FLAG_W*c +: msu_pkg::FLAG_W] = flags;
        assign busy_out[c] = state != msu_pkg::ST_IDLE;
        assign rx_line_level_out[c] = rxl_q;
    end

    // a receive-only channel has no send buffer to report on
    function automatic logic uart_rx_only(input logic rx_only);
        uart_rx_only = rx_only;
    endfunction : uart_rx_only
endmodule : multi_mode_serial_unit

`default_nettype wire

// file: src/unused_guard_note.sv
// intentionally empty companion file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: testbench/line_peer.sv
// far-side lines: async and clocked loopbacks, an unacknowledging two-wire target
`timescale 1ns/1ps
`default_nettype none
module line_peer (
    // lines driven by the unit
    input wire logic [3:0] so_out,
    input wire logic [3:0] so_oe_out,
    input wire logic [3:0] sck_out,
    // lines seen by the unit
    output logic [3:0] si_in,
    output logic [3:0] sck_in,
    output logic [3:0] slave_select_input_b_in
);
    // data lines 0 to 2 idle high through pull-ups; nobody ever pulls the ack bit low
    assign si_in = {so_oe_out[3] ? so_out[3] : ~so_out[3], ~so_oe_out[2], so_oe_out[0] ? so_out[0] : 1'b1, 1'b1};
    assign sck_in = sck_out;
    assign slave_select_input_b_in = 4'hF;
endmodule : line_peer
`default_nettype wire

// file: testbench/msu_props.sv
// assertions on the serial unit's ports
`timescale 1ns/1ps
`default_nettype none
module msu_props #(parameter int CHANNELS = 4) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // configuration and handshakes
    input wire logic [2*CHANNELS-1:0] mode_in,
    input wire logic [CHANNELS-1:0] invert_in,
    input wire logic [4*CHANNELS-1:0] flag_clear_in,
    input wire logic [CHANNELS-1:0] rx_ready_in,
    // observed outputs
    input wire logic [CHANNELS-1:0] rx_valid_out,
    input wire logic [CHANNELS-1:0] so_out,
    input wire logic [CHANNELS-1:0] busy_out,
    input wire logic [CHANNELS-1:0] done_out,
    input wire logic [CHANNELS-1:0] error_out,
    input wire logic [4*CHANNELS-1:0] flags_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);
    // channel 0 sends plain-level async frames in the bench
    wire logic tx_async = mode_in[1:0] == msu_pkg::MODE_ASYNC && !invert_in[0];
    a_done_pulse: assert property (done_out[1] |=> !done_out[1])
        else $error("done pulse held");
    a_done_busy: assert property (done_out[0] |-> busy_out[0] || $past(busy_out[0]) || $past(busy_out[0], 2))
        else $error("done without frame");
    a_idle_mark: assert property (tx_async && !busy_out[0] |-> so_out[0])
        else $error("idle line not mark");
    a_start_low: assert property (tx_async && $rose(busy_out[0]) |-> ##[0:2] !so_out[0])
        else $error("no start bit");
    a_flag_sticky: assert property (flags_out[4] && !flag_clear_in[4] |=> flags_out[4])
        else $error("overrun flag lost");
    a_err_pulse: assert property ($rose(flags_out[4]) |-> (error_out[1] || $past(error_out[1])) or (##1 error_out[1]))
        else $error("no error pulse");
    a_rx_hold: assert property (rx_valid_out[1] && !rx_ready_in[1] |=> rx_valid_out[1])
        else $error("received word dropped");
    a_nack_mode: assert property ($rose(flags_out[11]) |-> mode_in[5:4] == msu_pkg::MODE_TWO_WIRE)
        else $error("no-ack outside two-wire");
    c_rx_done: cover property (done_out[1]);
    c_overrun: cover property (flags_out[4]);
    c_nack: cover property (flags_out[11]);
endmodule : msu_props
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the serial unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int CHANNELS = 4;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] enable_in = 4'hF, master_in = 4'h8, msb_first_in = 4'h8, clk_pol_in = 4'h0;
    logic [3:0] clk_phase_in = 4'h0, invert_in = 4'h0, two_wire_read_in = 4'h0, ack_enable_in = 4'h0;
    logic [3:0] sw_clk_level_in = 4'hF, sw_data_level_in = 4'hF, tx_valid_in = 4'h0, rx_ready_in = 4'h4;
    logic [7:0] mode_in = 8'h3A, word_len_in = 8'h55, parity_in = 8'h05;
    logic [15:0] presc_sel_in = 16'h0000, flag_clear_in = 16'h0000, flags_out;
    logic [31:0] divider_in = 32'h03030303;
    logic [35:0] tx_data_in = 36'h0, rx_data_out;
    logic [3:0] tx_ready_out, rx_valid_out, sck_in, sck_out, sck_oe_out, si_in, so_out, so_oe_out;
    logic [3:0] slave_select_input_b_in, busy_out, done_out, buf_empty_out, error_out, rx_line_level_out;
    logic [8:0] w;
    logic [8:0] ow [3];
    logic [1:0] len = 2'h1;
    int err_count = 0, checks = 0, seed = 32'hC422;
    multi_mode_serial_unit #(.CHANNELS(CHANNELS)) dut (.mclk_in, .rst_b_in, .enable_in, .mode_in,
        .master_in, .word_len_in, .msb_first_in, .clk_pol_in, .clk_phase_in, .invert_in, .parity_in,
        .two_wire_read_in, .ack_enable_in, .presc_sel_in, .divider_in, .sw_clk_level_in,
        .sw_data_level_in, .flag_clear_in, .tx_data_in, .tx_valid_in, .tx_ready_out, .rx_data_out,
        .rx_valid_out, .rx_ready_in, .sck_in, .sck_out, .sck_oe_out, .si_in, .so_out, .so_oe_out,
        .slave_select_input_b_in, .flags_out, .busy_out, .done_out, .buf_empty_out, .error_out,
        .rx_line_level_out);
    line_peer peer (.so_out, .so_oe_out, .sck_out, .si_in, .sck_in, .slave_select_input_b_in);
    // 40 MHz clock
    always #12.5 mclk_in = ~mclk_in;
    // words shorter than nine bits come back with the upper bits cleared
    function automatic logic [8:0] expect_word(input logic [8:0] v, input logic [1:0] l);
        return l == msu_pkg::LEN_7 ? {2'h0, v[6:0]} : l == msu_pkg::LEN_8 ? {1'h0, v[7:0]} : v;
    endfunction : expect_word
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until the edge that sees ready high
    task automatic send(input int c, input logic [8:0] v);
        @(posedge mclk_in);
        tx_data_in[9*c +: 9] <= v;
        tx_valid_in[c] <= 1'b1;
        @(negedge mclk_in);
        while (tx_ready_out[c] !== 1'b1) @(negedge mclk_in);
        @(posedge mclk_in);
        tx_valid_in[c] <= 1'b0;
    endtask : send
    task automatic recv(input int c, input logic [8:0] e);
        @(negedge mclk_in);
        while (rx_valid_out[c] !== 1'b1) @(negedge mclk_in);
        chk(rx_data_out[9*c +: 9], e);
        @(posedge mclk_in);
        rx_ready_in[c] <= 1'b1;
        @(posedge mclk_in);
        rx_ready_in[c] <= 1'b0;
    endtask : recv
    // busy must stay low two cycles: queued frames restart after one idle cycle
    task automatic idle(input int c);
        repeat (4) @(negedge mclk_in);
        for (int n = 0; n < 2; n++) begin
            @(negedge mclk_in);
            if (busy_out[c] !== 1'b0) n = -1;
        end
    endtask : idle
    task automatic summarize();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // main sequence: every length and parity, overrun, then a refused address byte
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            w = 9'($random(seed));
            len = 2'(i % 3);
            word_len_in[3:0] <= {len, len};
            parity_in[3:0] <= {2{2'(i / 3)}};
            send(0, w);
            recv(1, expect_word(w, len));
            idle(0);
            send(3, w);
            recv(3, {1'h0, w[7:0]});
        end
        for (int k = 0; k < 3; k++) ow[k] = 9'($random(seed));
        for (int k = 0; k < 3; k++) send(0, ow[k]);
        idle(0);
        chk({8'h0, flags_out[4]}, 9'h001);
        recv(1, expect_word(ow[0], len));
        recv(1, expect_word(ow[2], len));
        @(posedge mclk_in);
        flag_clear_in[4] <= 1'b1;
        @(posedge mclk_in);
        flag_clear_in[4] <= 1'b0;
        @(negedge mclk_in);
        chk({8'h0, flags_out[4]}, 9'h000);
        send(2, {1'h0, w[7:1], 1'b0});
        idle(2);
        chk({8'h0, flags_out[11]}, 9'h001);
        summarize();
    end
    // hang guard
    initial begin
        #1000000;
        err_count++;
        summarize();
    end
endmodule : tb
bind multi_mode_serial_unit msu_props #(.CHANNELS(CHANNELS)) props (.mclk_in, .rst_b_in, .mode_in,
    .invert_in, .flag_clear_in, .rx_ready_in, .rx_valid_out, .so_out, .busy_out, .done_out,
    .error_out, .flags_out);
`default_nettype wire
